// [verilog/hsic_uframe_writeback.sv]
// Purpose: Writes back the bytes received in each microframe of a frame
//          into the three count words of a periodic interrupt descriptor.
// Assumes: sys_clk at 20 MHz, synchronous active-high reset, scheduler
//          inputs on the same clock, registers on a plain strobe port.
// Notes:   Read data stand for one cycle after the read strobe only.
//          A software mask write wins over a same-cycle hardware clear.
`include "hsic_map.svh"

module hsic_uframe_writeback
  import hsic_pkg::*;
#(
  parameter int NUM_UFRAMES = 8,
  parameter int COUNT_W = 12
)(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic [4:0] bus_frame,
  input wire hsic_uframe_t bus_uframe,
  input wire logic xfer_done,
  input wire hsic_count_t xfer_count,
  input wire hsic_result_t xfer_result,
  output logic uframe_serve
);

  // ========================================================================
  // Elaboration check
  // ========================================================================
  // The descriptor layout is fixed at eight 12-bit fields; any other
  // shape would not fit the three count words.
  generate
    if (NUM_UFRAMES != 8 || COUNT_W != 12) begin : g_bad_shape
      $error("hsic_uframe_writeback supports only 8 fields of 12 bits");
    end
  endgenerate

  // ========================================================================
  // State
  // ========================================================================
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [7:0] frame_reg;
  logic [7:0] frame_next;
  hsic_count_t count_reg [8];
  hsic_result_t result_reg [8];
  logic serve_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // ========================================================================
  // Register port decode
  // ========================================================================
  // Writes and reads are single strobes; no access ever waits.
  logic wr_mask;
  logic wr_frame;
  logic sel_mask;
  logic sel_frame;
  logic sel_status;
  logic sel_hi;
  logic sel_mid;
  logic sel_lo;
  logic sel_buspos;

  assign sel_mask = reg_addr == `HSIC_OFF_MASK;
  assign sel_frame = reg_addr == `HSIC_OFF_FRAME;
  assign sel_status = reg_addr == `HSIC_OFF_STATUS;
  assign sel_hi = reg_addr == `HSIC_OFF_HI;
  assign sel_mid = reg_addr == `HSIC_OFF_MID;
  assign sel_lo = reg_addr == `HSIC_OFF_LO;
  assign sel_buspos = reg_addr == `HSIC_OFF_BUSPOS;
  assign wr_mask = reg_write && sel_mask;
  assign wr_frame = reg_write && sel_frame;

  // ========================================================================
  // Microframe gate
  // ========================================================================
  logic frame_match;
  logic [7:0] uframe_onehot;
  logic uframe_enabled;
  logic [7:0] slot_write;

  hsic_uframe_gate u_gate (
    .activation_mask (mask_reg),
    .desc_frame (frame_reg),
    .bus_frame (bus_frame),
    .bus_uframe (bus_uframe),
    .frame_match (frame_match),
    .uframe_onehot (uframe_onehot),
    .uframe_enabled (uframe_enabled)
  );

  // The end of a served transaction picks exactly one slot; an unserved
  // microframe leaves every slot untouched.
  assign slot_write = (xfer_done && uframe_enabled) ? uframe_onehot
                                                    : 8'h00;

  // ========================================================================
  // Activation mask and descriptor frame
  // ========================================================================
  // A software write in the same cycle as a hardware clear wins, so a bit
  // that software re-arms is never lost to the clear.
  assign mask_next = wr_mask ? reg_wdata[7:0]
                             : (mask_reg & ~slot_write);
  assign frame_next = wr_frame ? reg_wdata[7:0] : frame_reg;

  // Mask and frame registers.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mask_reg <= `HSIC_MASK_RST;
      frame_reg <= `HSIC_FRAME_RST;
    end else begin
      mask_reg <= mask_next;
      frame_reg <= frame_next;
    end
  end

  // ========================================================================
  // Per-microframe count and result slots
  // ========================================================================
  hsic_pack_if pk ();
  logic [23:0] result_field;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_slot
      // Each slot keeps its last value until its own microframe is served.
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          count_reg[gi] <= `HSIC_COUNT_RST;
          result_reg[gi] <= `HSIC_RESULT_RST;
        end else if (slot_write[gi]) begin
          count_reg[gi] <= xfer_count;
          result_reg[gi] <= xfer_result;
        end
      end
      assign pk.count[gi] = count_reg[gi];
      assign result_field[gi*3 +: 3] = result_reg[gi];
    end
  endgenerate

  // Packing of the counts into the three words.
  hsic_count_pack u_pack (
    .pk (pk.packer)
  );

  // ========================================================================
  // Read path
  // ========================================================================
  // Status word: results above the mask, as the descriptor lays them out.
  logic [31:0] status_word;
  logic [31:0] buspos_word;
  logic [31:0] read_word;

  assign status_word = {result_field, mask_reg};
  assign buspos_word = {22'h000000, frame_match, uframe_enabled,
                        bus_frame, bus_uframe};
  // Unmapped addresses read as zero.
  assign read_word = sel_mask   ? {24'h000000, mask_reg}  :
                     sel_frame  ? {24'h000000, frame_reg} :
                     sel_status ? status_word             :
                     sel_hi     ? pk.hi_word              :
                     sel_mid    ? pk.mid_word             :
                     sel_lo     ? pk.lo_word              :
                     sel_buspos ? buspos_word             : 32'h00000000;
  // Data stand only in the cycle after the strobe, zero otherwise, so a
  // stale value can never be mistaken for a fresh read.
  assign rdata_next = reg_read ? read_word : 32'h00000000;

  // Read data and serve flag registers.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_reg <= 32'h00000000;
      serve_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      serve_reg <= uframe_enabled;
    end
  end

  assign reg_rdata = rdata_reg;
  assign uframe_serve = serve_reg;

  // ========================================================================
  // Assertions
  // ========================================================================
  // A served completion in a given microframe, with or without a software
  // write to the mask beside it.
  sequence served_done(int k);
    xfer_done && uframe_enabled && (bus_uframe == k);
  endsequence

  sequence unserved_done;
    xfer_done && !uframe_enabled;
  endsequence

  property count_lands(int k, logic [11:0] field);
    @(posedge sys_clk) disable iff (reset)
      served_done(k) |=> field == $past(xfer_count);
  endproperty

  u7_field_a: assert property (count_lands(7, pk.hi_word[31:20]))
    else $error("microframe 7 count not in upper word 31:20");

  u6_field_a: assert property (count_lands(6, pk.hi_word[19:8]))
    else $error("microframe 6 count not in upper word 19:8");

  u5_split_a: assert property (count_lands(5,
      {pk.hi_word[7:0], pk.mid_word[31:28]}))
    else $error("microframe 5 count split wrongly");

  u4_field_a: assert property (count_lands(4, pk.mid_word[27:16]))
    else $error("microframe 4 count not in middle word 27:16");

  u3_field_a: assert property (count_lands(3, pk.mid_word[15:4]))
    else $error("microframe 3 count not in middle word 15:4");

  u2_split_a: assert property (count_lands(2,
      {pk.mid_word[3:0], pk.lo_word[31:24]}))
    else $error("microframe 2 count split wrongly");

  u1_field_a: assert property (count_lands(1, pk.lo_word[23:12]))
    else $error("microframe 1 count not in lower word 23:12");

  u0_field_a: assert property (count_lands(0, pk.lo_word[11:0]))
    else $error("microframe 0 count not in lower word 11:0");

  unserved_hold_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      unserved_done |=> (pk.hi_word == $past(pk.hi_word))
                        && (pk.mid_word == $past(pk.mid_word))
                        && (pk.lo_word == $past(pk.lo_word)))
    else $error("counts changed for an unserved microframe");

  serve_gate_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      (frame_match && mask_reg[bus_uframe]) |=> uframe_serve)
    else $error("serve flag missing for an armed microframe");

  serve_frame_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      (frame_reg[7:3] != bus_frame) |=> !uframe_serve)
    else $error("serve flag raised with wrong frame");

  mask_clear_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      (xfer_done && uframe_enabled && !wr_mask)
        |=> !mask_reg[$past(bus_uframe)])
    else $error("mask bit not cleared after serving");

  mask_write_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      wr_mask |=> mask_reg == $past(reg_wdata[7:0]))
    else $error("software mask write lost");

  result_store_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      (xfer_done && uframe_enabled)
        |=> result_reg[$past(bus_uframe)] == $past(xfer_result))
    else $error("result code not recorded");

  read_status_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      (reg_read && sel_status && !xfer_done && !reg_write)
        |=> reg_rdata[10:8] == result_reg[0])
    else $error("status read does not show microframe 0 result");

  rdata_idle_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      !reg_read |=> reg_rdata == 32'h00000000)
    else $error("read data present without a read strobe");

  // Each count word read back is the word that stood at the read edge; a
  // completion in that same cycle only shows on the following read.
  read_upper_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      (reg_read && sel_hi) |=> reg_rdata == $past(pk.hi_word))
    else $error("upper count word read back wrongly");

  read_middle_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      (reg_read && sel_mid) |=> reg_rdata == $past(pk.mid_word))
    else $error("middle count word read back wrongly");

  read_lower_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      (reg_read && sel_lo) |=> reg_rdata == $past(pk.lo_word))
    else $error("lower count word read back wrongly");

  // Hardware may only clear mask bits; a bit that rose on its own would
  // arm a microframe that software never asked for.
  mask_no_set_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      !wr_mask |=> (mask_reg & ~$past(mask_reg)) == 8'h00)
    else $error("mask bit set without a software write");

  // Without a write or a served completion the mask stays put.
  mask_keep_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      (!wr_mask && !(xfer_done && uframe_enabled))
        |=> mask_reg == $past(mask_reg))
    else $error("mask changed with nothing served");

  // A refused completion must leave every result slot alone.
  result_keep_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      unserved_done |=> result_field == $past(result_field))
    else $error("result changed for an unserved microframe");

  // One completion fills one slot at most, never two.
  one_slot_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      xfer_done |-> $onehot0(slot_write))
    else $error("more than one count slot written");

  // The descriptor frame register takes a software write whole.
  frame_write_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      wr_frame |=> frame_reg == $past(reg_wdata[7:0]))
    else $error("descriptor frame write lost");

  // A served completion, then one quiet cycle on the same microframe.
  sequence served_then_quiet;
    (xfer_done && uframe_enabled && !wr_mask)
      ##1 ($stable(bus_uframe) && !wr_mask);
  endsequence

  // Once its mask bit is cleared the microframe must stop being served.
  serve_drop_a: assert property (
    @(posedge sys_clk) disable iff (reset)
      served_then_quiet |=> !uframe_serve)
    else $error("serve flag stayed up after its mask bit cleared");

endmodule : hsic_uframe_writeback

// [verilog/hsic_map.svh]
// Purpose: Offsets, field positions and reset values for the microframe
//          byte count write-back block.
// Assumes: Byte addresses on an 8-bit register port, 32-bit data.
// Notes:   Definitions only; included by the modules and the bench.
`ifndef HSIC_MAP_SVH
`define HSIC_MAP_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define HSIC_OFF_MASK 8'h00
`define HSIC_OFF_FRAME 8'h04
`define HSIC_OFF_STATUS 8'h08
`define HSIC_OFF_HI 8'h0C
`define HSIC_OFF_MID 8'h10
`define HSIC_OFF_LO 8'h14
`define HSIC_OFF_BUSPOS 8'h18

// ==========================================================================
// Reset values
// ==========================================================================
`define HSIC_MASK_RST 8'h00
`define HSIC_FRAME_RST 8'h00
`define HSIC_COUNT_RST 12'h000
`define HSIC_RESULT_RST 3'h0

// ==========================================================================
// Field positions (least significant bit of each field) and the status field width
// ==========================================================================
`define HSIC_HI_U7_LSB 20
`define HSIC_HI_U6_LSB 8
`define HSIC_HI_U5H_LSB 0
`define HSIC_MID_U5L_LSB 28
`define HSIC_MID_U4_LSB 16
`define HSIC_MID_U3_LSB 4
`define HSIC_MID_U2H_LSB 0
`define HSIC_LO_U2L_LSB 24
`define HSIC_LO_U1_LSB 12
`define HSIC_LO_U0_LSB 0
`define HSIC_STAT_LSB 8
`define HSIC_STAT_W 3
`define HSIC_FRAME_CMP_LSB 3
`define HSIC_RES_XACT_ERR 0
`define HSIC_RES_BABBLE 1
`define HSIC_RES_UNDERRUN 2

`endif

// [verilog/hsic_pkg.sv]
// Purpose: Shared types of the microframe byte count write-back block.
// Assumes: Field positions and offsets live in hsic_map.svh.
// Notes:   Types only.
// ==========================================================================
// Types
// ==========================================================================
package hsic_pkg;
  typedef logic [11:0] hsic_count_t;
  typedef logic [2:0] hsic_result_t;
  typedef logic [2:0] hsic_uframe_t;
endpackage : hsic_pkg

// [verilog/hsic_pack_if.sv]
// Purpose: Carries the eight stored counts to the packer and the three
//          packed words back.
// Assumes: Single clock; the packer is purely combinational.
// Notes:   None.
// ==========================================================================
// Count packing interface
// ==========================================================================
interface hsic_pack_if;
  import hsic_pkg::*;
  hsic_count_t count [8];
  logic [31:0] hi_word;
  logic [31:0] mid_word;
  logic [31:0] lo_word;
  modport store (output count, input hi_word, input mid_word, input lo_word);
  modport packer (input count, output hi_word, output mid_word,
                  output lo_word);
endinterface : hsic_pack_if

// [verilog/hsic_count_pack.sv]
// Purpose: Lays the eight 12-bit counts into the three descriptor words.
// Assumes: Counts are held in flip-flops by the caller.
// Notes:   Two counts straddle a word boundary.
`include "hsic_map.svh"

// ==========================================================================
// Count packer
// ==========================================================================
module hsic_count_pack
  import hsic_pkg::*;
(
  hsic_pack_if.packer pk
);
  // Upper word holds microframes 7, 6 and the top of 5.
  assign pk.hi_word[`HSIC_HI_U7_LSB +: 12] = pk.count[7];
  assign pk.hi_word[`HSIC_HI_U6_LSB +: 12] = pk.count[6];
  assign pk.hi_word[`HSIC_HI_U5H_LSB +: 8] = pk.count[5][11:4];

  // Middle word holds the tail of 5, then 4, 3 and the top of 2.
  assign pk.mid_word[`HSIC_MID_U5L_LSB +: 4] = pk.count[5][3:0];
  assign pk.mid_word[`HSIC_MID_U4_LSB +: 12] = pk.count[4];
  assign pk.mid_word[`HSIC_MID_U3_LSB +: 12] = pk.count[3];
  assign pk.mid_word[`HSIC_MID_U2H_LSB +: 4] = pk.count[2][11:8];

  // Lower word holds the tail of 2, then 1 and 0.
  assign pk.lo_word[`HSIC_LO_U2L_LSB +: 8] = pk.count[2][7:0];
  assign pk.lo_word[`HSIC_LO_U1_LSB +: 12] = pk.count[1];
  assign pk.lo_word[`HSIC_LO_U0_LSB +: 12] = pk.count[0];
endmodule : hsic_count_pack

// [verilog/hsic_uframe_gate.sv]
// Purpose: Decides whether the current microframe is to be served.
// Assumes: All inputs come from logic on the same clock.
// Notes:   Combinational; the caller registers what leaves the block.
`include "hsic_map.svh"

// ==========================================================================
// Microframe gate
// ==========================================================================
module hsic_uframe_gate
  import hsic_pkg::*;
(
  input wire logic [7:0] activation_mask,
  input wire logic [7:0] desc_frame,
  input wire logic [4:0] bus_frame,
  input wire hsic_uframe_t bus_uframe,
  output logic frame_match,
  output logic [7:0] uframe_onehot,
  output logic uframe_enabled
);
  // Only the frame bits of the descriptor field are compared; the low
  // three bits name a microframe and must not spoil the match.
  assign frame_match = desc_frame[7:`HSIC_FRAME_CMP_LSB] == bus_frame;
  assign uframe_onehot = 8'h01 << bus_uframe;
  // A microframe is served only with its mask bit set and the frame right.
  assign uframe_enabled = frame_match
                          && ((activation_mask & uframe_onehot) != 8'h00);
endmodule : hsic_uframe_gate

// [test/hsic_endpoint_model.sv]
// Purpose: Behaves as the interrupt IN endpoint on the far side of the
//          write-back block, ending one transaction when told to.
// Assumes: One clock; the bench says when the host token has gone out.
// Notes:   Outside its one-cycle done pulse the data lines are treated as
//          released, so they toggle every cycle instead of holding.

// ==========================================================================
// Endpoint model
// ==========================================================================
module hsic_endpoint_model
  import hsic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic go,
  input wire hsic_count_t send_count,
  input wire hsic_result_t send_result,
  input wire logic [3:0] send_delay,
  output logic xfer_done,
  output hsic_count_t xfer_count,
  output hsic_result_t xfer_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_reg;
  logic armed_reg;
  hsic_count_t cnt_reg;
  hsic_result_t res_reg;

  // Answer after a chosen delay; a slow endpoint is just a longer delay.
  always_ff @(posedge sys_clk) begin
    xfer_done <= 1'b0;
    xfer_count <= ~xfer_count;
    xfer_result <= ~xfer_result;
    if (reset) begin
      armed_reg <= 1'b0;
      wait_reg <= 4'h0;
      xfer_count <= 12'h000;
      xfer_result <= 3'h0;
    end else if (go) begin
      armed_reg <= 1'b1;
      wait_reg <= send_delay;
      cnt_reg <= send_count;
      res_reg <= send_result;
    end else if (armed_reg && wait_reg == 4'h0) begin
      xfer_done <= 1'b1;
      xfer_count <= cnt_reg;
      xfer_result <= res_reg;
      armed_reg <= 1'b0;
    end else if (armed_reg) begin
      wait_reg <= wait_reg - 4'h1;
    end
  end
endmodule : hsic_endpoint_model

// [test/hsic_uframe_writeback_tb_top.sv]
// Purpose: Self-checking bench for the microframe count write-back block.
// Assumes: Registers on the strobe port, endpoint model on the far side.
// Notes:   Table rows first, then reset and the odd cases by hand.
`include "hsic_map.svh"

// ==========================================================================
// Bench top
// ==========================================================================
module hsic_uframe_writeback_tb_top
  import hsic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [4:0] desc_fr;
    logic [7:0] mask;
    logic [4:0] bus_fr;
    hsic_uframe_t uf;
    hsic_count_t cnt;
    hsic_result_t res;
    logic [3:0] dly;
    logic hit;
  } hsic_row_s;

  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [4:0] bus_frame = 5'h00;
  hsic_uframe_t bus_uframe = 3'h0;
  logic xfer_done;
  hsic_count_t xfer_count;
  hsic_result_t xfer_result;
  logic uframe_serve;
  logic go = 1'b0;
  hsic_count_t send_count = 12'h000;
  hsic_result_t send_result = 3'h0;
  logic [3:0] send_delay = 4'h0;
  hsic_count_t exp_cnt [8];
  hsic_result_t exp_res [8];
  logic [7:0] exp_mask;
  hsic_row_s rows [10];
  int n_mismatch = 0;
  int checked = 0;

  hsic_uframe_writeback #(.NUM_UFRAMES(8), .COUNT_W(12))
  hsic_uframe_writeback_i (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .bus_frame(bus_frame),
    .bus_uframe(bus_uframe), .xfer_done(xfer_done),
    .xfer_count(xfer_count), .xfer_result(xfer_result),
    .uframe_serve(uframe_serve));

  hsic_endpoint_model hsic_endpoint_model_i (.sys_clk(sys_clk),
    .reset(reset), .go(go), .send_count(send_count),
    .send_result(send_result), .send_delay(send_delay),
    .xfer_done(xfer_done), .xfer_count(xfer_count),
    .xfer_result(xfer_result));

  // ==========================================================================
  // Clock and watchdog
  // ==========================================================================
  // The watchdog span is dozens of times the longest expected run.
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Every comparison goes through here so the counts stay honest.
  task automatic check32(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : check32

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    check32(what, exp, reg_rdata);
  endtask : reg_rd

  task automatic check_words();
    reg_rd(`HSIC_OFF_HI, {exp_cnt[7], exp_cnt[6], exp_cnt[5][11:4]},
           "upper");
    reg_rd(`HSIC_OFF_MID, {exp_cnt[5][3:0], exp_cnt[4], exp_cnt[3],
           exp_cnt[2][11:8]}, "middle");
    reg_rd(`HSIC_OFF_LO, {exp_cnt[2][7:0], exp_cnt[1], exp_cnt[0]},
           "lower");
    reg_rd(`HSIC_OFF_STATUS, {exp_res[7], exp_res[6], exp_res[5],
           exp_res[4], exp_res[3], exp_res[2], exp_res[1], exp_res[0],
           exp_mask}, "status");
  endtask : check_words

  // Put the bus on one microframe and let the endpoint finish a transfer.
  task automatic serve_one(input hsic_row_s r);
    int n;
    @(posedge sys_clk);
    bus_frame <= r.bus_fr;
    bus_uframe <= r.uf;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check32("serve", {31'h0, r.hit}, {31'h0, uframe_serve});
    @(posedge sys_clk);
    go <= 1'b1;
    send_count <= r.cnt;
    send_result <= r.res;
    send_delay <= r.dly;
    @(posedge sys_clk);
    go <= 1'b0;
    n = 0;
    while (xfer_done !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    check32("done wait", 32'h0, {31'h0, n == 40});
    if (r.hit) begin
      exp_cnt[r.uf] = r.cnt;
      exp_res[r.uf] = r.res;
      exp_mask[r.uf] = 1'b0;
    end
    @(posedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check32("serve after", 32'h0, {31'h0, uframe_serve});
  endtask : serve_one

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  // Low frame bits are written as 101 to show that only bits 7:3 compare.
  initial begin
    rows = '{
      '{5'h01, 8'h01, 5'h01, 3'h0, 12'h123, 3'h1, 4'h0, 1'b1},
      '{5'h02, 8'h02, 5'h02, 3'h1, 12'hFFF, 3'h2, 4'h3, 1'b1},
      '{5'h03, 8'h04, 5'h03, 3'h2, 12'hA5C, 3'h4, 4'h1, 1'b1},
      '{5'h1F, 8'h08, 5'h1F, 3'h3, 12'h001, 3'h0, 4'h9, 1'b1},
      '{5'h10, 8'hFF, 5'h10, 3'h4, 12'h800, 3'h3, 4'h0, 1'b1},
      '{5'h01, 8'h20, 5'h01, 3'h5, 12'hABC, 3'h2, 4'h2, 1'b1},
      '{5'h07, 8'h40, 5'h07, 3'h6, 12'h7E1, 3'h5, 4'h0, 1'b1},
      '{5'h0A, 8'h80, 5'h0A, 3'h7, 12'h3D9, 3'h7, 4'hF, 1'b1},
      '{5'h05, 8'hFE, 5'h05, 3'h0, 12'h555, 3'h1, 4'h0, 1'b0},
      '{5'h04, 8'h80, 5'h05, 3'h7, 12'h0F0, 3'h2, 4'h0, 1'b0}};
    foreach (exp_cnt[k]) begin
      exp_cnt[k] = 12'h000;
      exp_res[k] = 3'h0;
    end
    exp_mask = 8'h00;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    check_words();
    foreach (rows[i]) begin
      reg_wr(`HSIC_OFF_FRAME, {24'h0, rows[i].desc_fr, 3'h5});
      reg_wr(`HSIC_OFF_MASK, {24'h0, rows[i].mask});
      reg_rd(`HSIC_OFF_FRAME, {24'h0, rows[i].desc_fr, 3'h5}, "frame");
      exp_mask = rows[i].mask;
      serve_one(rows[i]);
      check_words();
    end
    // Read-only words must ignore software; read data fall back to zero.
    reg_wr(`HSIC_OFF_HI, 32'hFFFFFFFF);
    check_words();
    @(posedge sys_clk);
    @(negedge sys_clk);
    check32("rdata idle", 32'h0, reg_rdata);
    reg_rd(8'h1C, 32'h0, "unmapped");
    // A second reset in mid-run clears everything again, serve flag too.
    reg_wr(`HSIC_OFF_FRAME, 32'h2D);
    @(posedge sys_clk);
    reset <= 1'b1;
    bus_frame <= 5'h00;
    bus_uframe <= 3'h0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check32("serve reset", 32'h0, {31'h0, uframe_serve});
    @(posedge sys_clk);
    reset <= 1'b0;
    foreach (exp_cnt[k]) begin
      exp_cnt[k] = 12'h000;
      exp_res[k] = 3'h0;
    end
    exp_mask = 8'h00;
    check_words();
    reg_rd(`HSIC_OFF_BUSPOS, 32'h200, "bus position");
    // Two neighbours back to back, then a repeat on a cleared bit.
    reg_wr(`HSIC_OFF_MASK, 32'h03);
    exp_mask = 8'h03;
    serve_one('{5'h00, 8'h03, 5'h00, 3'h0, 12'h6A2, 3'h1, 4'h0, 1'b1});
    serve_one('{5'h00, 8'h03, 5'h00, 3'h1, 12'h19E, 3'h6, 4'h0, 1'b1});
    serve_one('{5'h00, 8'h00, 5'h00, 3'h0, 12'h0AA, 3'h4, 4'h0, 1'b0});
    check_words();
    reg_wr(`HSIC_OFF_MASK, 32'h01);
    exp_mask = 8'h01;
    serve_one('{5'h00, 8'h01, 5'h00, 3'h0, 12'hC03, 3'h0, 4'h4, 1'b1});
    check_words();
    test_done();
  end
endmodule : hsic_uframe_writeback_tb_top
